// ===== core/cal_pkg.sv
`default_nettype none
package cal_pkg;
    // ==========================================
    // threshold defaults, mAh
    localparam logic [15:0] CAL_INITIAL_CAPACITY_ALARM_SET_RST  = 16'h0096;
    localparam logic [15:0] CAL_INITIAL_CAPACITY_ALARM_CLR_RST  = 16'h00AF;
    localparam logic [15:0] CAL_FINAL_CAPACITY_ALARM_SET_RST  = 16'h004B;
    localparam logic [15:0] CAL_FINAL_CAPACITY_ALARM_CLR_RST  = 16'h0064;
    localparam logic [15:0] CAL_SET_DISABLED  = 16'hFFFF;
    // ==========================================
    // load model and rate source encodings
    localparam logic        CAL_MODE_CURRENT  = 1'h0;
    localparam logic        CAL_MODE_POWER    = 1'h1;
    localparam logic [2:0]  CAL_SEL_RST       = 3'h1;
    // ==========================================
    // flag word and control word bit positions
    localparam int          CAL_FLG_FINAL_CAPACITY_ALARM      = 1;
    localparam int          CAL_FLG_INITIAL_CAPACITY_ALARM      = 2;
    localparam int          CAL_FLG_TDD       = 3;
    localparam int          CAL_FLG_ISD       = 4;
    localparam int          CAL_CTL_LOAD_MODEL_INDICATOR      = 3;
    // ==========================================
    // low-pass filter: 14 s time constant, 20 MHz clock
    localparam int          CAL_TAU_S         = 14;
    localparam int          CAL_CLK_HZ        = 20000000;
    localparam logic [15:0] CAL_FLG_RST       = 16'h0000;
    localparam logic [15:0] CAL_RATE_RST      = 16'h0000;

    typedef enum logic [2:0] {
        CAL_SRC_LAST    = 3'b000,
        CAL_SRC_PRESENT = 3'b001,
        CAL_SRC_AVG     = 3'b010,
        CAL_SRC_FILT    = 3'b011,
        CAL_SRC_DESIGN  = 3'b100,
        CAL_SRC_HOST    = 3'b101,
        CAL_SRC_USER    = 3'b110
    } cal_src_t;
endpackage
`default_nettype wire

// ===== core/cal_lpf.sv
`default_nettype none
module cal_lpf
    import cal_pkg::*;
#(
    parameter int SHIFT = 4
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               sample,
    input  wire logic signed [15:0] din,
    output var  logic signed [15:0] dout
);
    // ==========================================
    // first order filter, updated once per sample tick
    logic signed [31:0] acc_ff;
    logic signed [31:0] nxt_acc;

    always_comb begin
        nxt_acc = acc_ff;
        if (sample) begin
            // acc settles at din shifted up by SHIFT bits, so the output is taken from that slice
            nxt_acc = acc_ff + 32'(din) - (acc_ff >>> SHIFT);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= 32'h00000000;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    assign dout = acc_ff[SHIFT +: 16];
endmodule
`default_nettype wire

// ===== core/cal_core.sv
`default_nettype none
// Function
// (R1) set initial alarm when remaining charge falls below its set threshold
// (R2) clear initial alarm only when charge rises above its clear threshold
// (R3) set final alarm when remaining charge falls below final set threshold
// (R4) final set threshold of minus one disables setting the final alarm
// (R5) clear final alarm only if set and charge above final clear threshold
// (R6) internal short flag follows relaxed-voltage short detection
// (R7) tab disconnect flag follows health-based tab detection, two parallel cells
// (R8) load model zero, the default, selects constant-current compensation
// (R9) load model one selects constant-power compensation
// (R10) control status word mirrors load model in an indicator bit
// (R11) current mode source zero: previous cycle average discharge current
// (R12) current mode source one, default: present cycle average discharge current
// (R13) current sources two and three: average current, 14 s filtered average
// (R14) current source four: design capacity divided by five
// (R15) current sources five and six: host-requested rate, user current rate
// (R16) power sources zero and one: previous and present cycle average power
// (R17) power sources two and three: average and filtered current times voltage
// (R18) power source four: design energy divided by five
// (R19) power sources five and six: host-requested rate, user power rate
// (R20) full charge capacity reported from gauge result at terminate voltage
// (R21) thresholds default to 150, 175, 75 and 100 mAh
// (R22) alarms re-evaluated on each new remaining charge value, word updated atomically
module cal_core
    import cal_pkg::*;
#(
    parameter int          FILT_SHIFT = 4,
    parameter logic [15:0] INITIAL_CAPACITY_ALARM_SET   = CAL_INITIAL_CAPACITY_ALARM_SET_RST,
    parameter logic [15:0] INITIAL_CAPACITY_ALARM_CLR   = CAL_INITIAL_CAPACITY_ALARM_CLR_RST,
    parameter logic [15:0] FINAL_CAPACITY_ALARM_SET   = CAL_FINAL_CAPACITY_ALARM_SET_RST,
    parameter logic [15:0] FINAL_CAPACITY_ALARM_CLR   = CAL_FINAL_CAPACITY_ALARM_CLR_RST
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] initial_capacity_alarm_set_thr,
    input  wire logic [15:0] initial_capacity_alarm_clr_thr,
    input  wire logic [15:0] final_capacity_alarm_set_thr,
    input  wire logic [15:0] final_capacity_alarm_clr_thr,
    input  wire logic        thr_load,
    input  wire logic [15:0] remaining_charge,
    input  wire logic        remaining_valid,
    input  wire logic        short_detect,
    input  wire logic        tab_detect,
    input  wire logic        load_mode,
    input  wire logic [2:0]  load_select,
    input  wire logic [15:0] avg_i_last_run,
    input  wire logic [15:0] avg_i_present,
    input  wire logic [15:0] average_current_reading,
    input  wire logic [15:0] voltage_mv,
    input  wire logic [15:0] avg_p_last_run,
    input  wire logic [15:0] avg_p_present,
    input  wire logic [15:0] design_capacity,
    input  wire logic [15:0] design_energy,
    input  wire logic [15:0] host_requested_rate,
    input  wire logic [15:0] user_current_rate,
    input  wire logic [15:0] user_power_rate,
    input  wire logic        filt_tick,
    input  wire logic [15:0] fcc_in,
    input  wire logic        fcc_valid,
    output var  logic [15:0] flag_word,
    output var  logic [15:0] control_status,
    output var  logic [15:0] comp_rate,
    output var  logic        comp_power_mode,
    output var  logic [15:0] full_charge_capacity_a
);
    // ==========================================
    // reset release
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic srst_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign srst_n = rst_s2_ff;

    // ==========================================
    // detector pins: three-stage sync, change counts when stages two and three agree
    logic [2:0] isd_sync_ff;
    logic [2:0] tdd_sync_ff;
    logic       isd_ff;
    logic       tdd_ff;
    logic       nxt_isd;
    logic       nxt_tdd;

    always_comb begin
        nxt_isd = isd_ff;
        nxt_tdd = tdd_ff;
        if (isd_sync_ff[1] == isd_sync_ff[2]) begin
            nxt_isd = isd_sync_ff[2];
        end
        if (tdd_sync_ff[1] == tdd_sync_ff[2]) begin
            nxt_tdd = tdd_sync_ff[2];
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            isd_sync_ff <= 3'h0;
            tdd_sync_ff <= 3'h0;
            isd_ff      <= 1'b0;
            tdd_ff      <= 1'b0;
        end else begin
            isd_sync_ff <= {isd_sync_ff[1:0], short_detect};
            tdd_sync_ff <= {tdd_sync_ff[1:0], tab_detect};
            isd_ff      <= nxt_isd;
            tdd_ff      <= nxt_tdd;
        end
    end

    // ==========================================
    // threshold registers
    logic [15:0] initial_capacity_alarm_set_ff;
    logic [15:0] initial_capacity_alarm_clr_ff;
    logic [15:0] final_capacity_alarm_set_ff;
    logic [15:0] final_capacity_alarm_clr_ff;
    logic [15:0] nxt_initial_capacity_alarm_set;
    logic [15:0] nxt_initial_capacity_alarm_clr;
    logic [15:0] nxt_final_capacity_alarm_set;
    logic [15:0] nxt_final_capacity_alarm_clr;

    always_comb begin
        nxt_initial_capacity_alarm_set = initial_capacity_alarm_set_ff;
        nxt_initial_capacity_alarm_clr = initial_capacity_alarm_clr_ff;
        nxt_final_capacity_alarm_set = final_capacity_alarm_set_ff;
        nxt_final_capacity_alarm_clr = final_capacity_alarm_clr_ff;
        if (thr_load) begin
            nxt_initial_capacity_alarm_set = initial_capacity_alarm_set_thr;
            nxt_initial_capacity_alarm_clr = initial_capacity_alarm_clr_thr;
            nxt_final_capacity_alarm_set = final_capacity_alarm_set_thr;
            nxt_final_capacity_alarm_clr = final_capacity_alarm_clr_thr;
        end
    end

    // (R21) reset defaults
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            initial_capacity_alarm_set_ff <= INITIAL_CAPACITY_ALARM_SET;
            initial_capacity_alarm_clr_ff <= INITIAL_CAPACITY_ALARM_CLR;
            final_capacity_alarm_set_ff <= FINAL_CAPACITY_ALARM_SET;
            final_capacity_alarm_clr_ff <= FINAL_CAPACITY_ALARM_CLR;
        end else begin
            initial_capacity_alarm_set_ff <= nxt_initial_capacity_alarm_set;
            initial_capacity_alarm_clr_ff <= nxt_initial_capacity_alarm_clr;
            final_capacity_alarm_set_ff <= nxt_final_capacity_alarm_set;
            final_capacity_alarm_clr_ff <= nxt_final_capacity_alarm_clr;
        end
    end

    // ==========================================
    // capacity alarms
    logic initial_capacity_alarm_ff;
    logic final_capacity_alarm_ff;
    logic nxt_initial_capacity_alarm;
    logic nxt_final_capacity_alarm;

    always_comb begin
        nxt_initial_capacity_alarm = initial_capacity_alarm_ff;
        nxt_final_capacity_alarm = final_capacity_alarm_ff;
        // (R22) evaluate on each new value
        if (remaining_valid) begin
            // (R1) initial set
            if (remaining_charge < initial_capacity_alarm_set_ff) begin
                nxt_initial_capacity_alarm = 1'b1;
            // (R2) initial clear
            end else if (remaining_charge > initial_capacity_alarm_clr_ff) begin
                nxt_initial_capacity_alarm = 1'b0;
            end
            // (R3) final set, (R4) minus one disables
            if (final_capacity_alarm_set_ff != CAL_SET_DISABLED && remaining_charge < final_capacity_alarm_set_ff) begin
                nxt_final_capacity_alarm = 1'b1;
            // (R5) final clear only if set
            end else if (final_capacity_alarm_ff && remaining_charge > final_capacity_alarm_clr_ff) begin
                nxt_final_capacity_alarm = 1'b0;
            end
        end
    end

    // ==========================================
    // flag and control words, rebuilt as a whole so a read never sees half an update
    logic [15:0] flag_ff;
    logic [15:0] nxt_flag;
    logic [15:0] ctl_ff;
    logic [15:0] nxt_ctl;
    logic        mode_ff;

    always_comb begin
        // (R22) atomic word update
        nxt_flag               = CAL_FLG_RST;
        nxt_flag[CAL_FLG_INITIAL_CAPACITY_ALARM] = nxt_initial_capacity_alarm;
        nxt_flag[CAL_FLG_FINAL_CAPACITY_ALARM] = nxt_final_capacity_alarm;
        // (R6) internal short flag
        nxt_flag[CAL_FLG_ISD]  = isd_ff;
        // (R7) tab disconnect flag
        nxt_flag[CAL_FLG_TDD]  = tdd_ff;
        nxt_ctl                = 16'h0000;
        // (R10) load model indicator
        nxt_ctl[CAL_CTL_LOAD_MODEL_INDICATOR]  = load_mode;
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            initial_capacity_alarm_ff <= 1'b0;
            final_capacity_alarm_ff <= 1'b0;
            flag_ff <= CAL_FLG_RST;
            ctl_ff  <= 16'h0000;
            mode_ff <= CAL_MODE_CURRENT;
        end else begin
            initial_capacity_alarm_ff <= nxt_initial_capacity_alarm;
            final_capacity_alarm_ff <= nxt_final_capacity_alarm;
            flag_ff <= nxt_flag;
            ctl_ff  <= nxt_ctl;
            mode_ff <= load_mode;
        end
    end

    // ==========================================
    // rate source selection
    logic [15:0] filt_i;
    logic [15:0] rate_ff;
    logic [15:0] nxt_rate;
    logic [15:0] fcc_ff;
    logic [15:0] nxt_fcc;

    // (R13) 14 s filtered average current
    cal_lpf #(
        .SHIFT (FILT_SHIFT)
    ) u_lpf (
        .clk   (clk),
        .rst_n (srst_n),
        .sample(filt_tick),
        .din   (average_current_reading),
        .dout  (filt_i)
    );

    // power from mA and mV as the product divided by 1024; sign kept from current
    function automatic logic [15:0] cal_mul_iv(input logic [15:0] i, input logic [15:0] v);
        logic signed [31:0] p;
        p = 32'($signed(i)) * 32'($signed({1'b0, v[14:0]}));
        return p[25:10];
    endfunction

    function automatic logic [15:0] cal_div5(input logic [15:0] x);
        return x / 16'h0005;
    endfunction

    always_comb begin
        nxt_rate = CAL_RATE_RST;
        // (R8) current model when mode is zero
        if (load_mode == CAL_MODE_CURRENT) begin
            unique case (cal_src_t'(load_select))
                // (R11) previous cycle current
                CAL_SRC_LAST:    nxt_rate = avg_i_last_run;
                // (R12) present cycle current
                CAL_SRC_PRESENT: nxt_rate = avg_i_present;
                // (R13) average and filtered
                CAL_SRC_AVG:     nxt_rate = average_current_reading;
                CAL_SRC_FILT:    nxt_rate = filt_i;
                // (R14) C/5 from design capacity
                CAL_SRC_DESIGN:  nxt_rate = cal_div5(design_capacity);
                // (R15) host and user rates
                CAL_SRC_HOST:    nxt_rate = host_requested_rate;
                CAL_SRC_USER:    nxt_rate = user_current_rate;
                default:         nxt_rate = avg_i_present;
            endcase
        // (R9) power model when mode is one
        end else begin
            unique case (cal_src_t'(load_select))
                // (R16) previous and present power
                CAL_SRC_LAST:    nxt_rate = avg_p_last_run;
                CAL_SRC_PRESENT: nxt_rate = avg_p_present;
                // (R17) current times voltage
                CAL_SRC_AVG:     nxt_rate = cal_mul_iv(average_current_reading, voltage_mv);
                CAL_SRC_FILT:    nxt_rate = cal_mul_iv(filt_i, voltage_mv);
                // (R18) design energy over five
                CAL_SRC_DESIGN:  nxt_rate = cal_div5(design_energy);
                // (R19) host and user power rates
                CAL_SRC_HOST:    nxt_rate = host_requested_rate;
                CAL_SRC_USER:    nxt_rate = user_power_rate;
                default:         nxt_rate = avg_p_present;
            endcase
        end
        nxt_fcc = fcc_ff;
        // (R20) capture gauge fcc result
        if (fcc_valid) begin
            nxt_fcc = fcc_in;
        end
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            rate_ff <= CAL_RATE_RST;
            fcc_ff  <= 16'h0000;
        end else begin
            rate_ff <= nxt_rate;
            fcc_ff  <= nxt_fcc;
        end
    end

    assign flag_word              = flag_ff;
    assign control_status         = ctl_ff;
    assign comp_rate              = rate_ff;
    assign comp_power_mode        = mode_ff;
    assign full_charge_capacity_a = fcc_ff;
endmodule
`default_nettype wire

// ===== test/cal_core_chk.sv
`default_nettype none
module cal_core_chk
    import cal_pkg::*;
#(
    parameter logic [15:0] INITIAL_CAPACITY_ALARM_SET = CAL_INITIAL_CAPACITY_ALARM_SET_RST,
    parameter logic [15:0] INITIAL_CAPACITY_ALARM_CLR = CAL_INITIAL_CAPACITY_ALARM_CLR_RST,
    parameter logic [15:0] FINAL_CAPACITY_ALARM_SET = CAL_FINAL_CAPACITY_ALARM_SET_RST,
    parameter logic [15:0] FINAL_CAPACITY_ALARM_CLR = CAL_FINAL_CAPACITY_ALARM_CLR_RST
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] initial_capacity_alarm_set_thr,
    input  wire logic [15:0] initial_capacity_alarm_clr_thr,
    input  wire logic [15:0] final_capacity_alarm_set_thr,
    input  wire logic [15:0] final_capacity_alarm_clr_thr,
    input  wire logic        thr_load,
    input  wire logic [15:0] remaining_charge,
    input  wire logic        remaining_valid,
    input  wire logic        short_detect,
    input  wire logic        tab_detect,
    input  wire logic        load_mode,
    input  wire logic [15:0] flag_word,
    input  wire logic [15:0] control_status,
    input  wire logic        comp_power_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // threshold shadow; up_ff hides the internal reset stretch
    logic [1:0]  up_ff;
    logic [15:0] is_ff;
    logic [15:0] ic_ff;
    logic [15:0] fs_ff;
    logic [15:0] fc_ff;
    logic        up;
    logic        vld;
    assign up = (up_ff == 2'h3);
    assign vld = up && remaining_valid;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_ff <= 2'h0;
            is_ff <= INITIAL_CAPACITY_ALARM_SET;
            ic_ff <= INITIAL_CAPACITY_ALARM_CLR;
            fs_ff <= FINAL_CAPACITY_ALARM_SET;
            fc_ff <= FINAL_CAPACITY_ALARM_CLR;
        end else begin
            if (!up) up_ff <= up_ff + 2'h1;
            if (up && thr_load) begin
                is_ff <= initial_capacity_alarm_set_thr;
                ic_ff <= initial_capacity_alarm_clr_thr;
                fs_ff <= final_capacity_alarm_set_thr;
                fc_ff <= final_capacity_alarm_clr_thr;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // assertions
    AST_INIT_SET: assert property (
        vld && remaining_charge < is_ff |=> flag_word[CAL_FLG_INITIAL_CAPACITY_ALARM]) else $error("init alarm not set");
    AST_INIT_CLR: assert property (
        vld && remaining_charge > ic_ff && remaining_charge >= is_ff |=> !flag_word[CAL_FLG_INITIAL_CAPACITY_ALARM])
        else $error("init alarm not cleared");
    AST_INIT_HOLD: assert property (
        up && !(vld && (remaining_charge < is_ff || remaining_charge > ic_ff))
        |=> $stable(flag_word[CAL_FLG_INITIAL_CAPACITY_ALARM])) else $error("init alarm moved");
    AST_FIN_SET: assert property (
        vld && remaining_charge < fs_ff && fs_ff != CAL_SET_DISABLED |=> flag_word[CAL_FLG_FINAL_CAPACITY_ALARM])
        else $error("final alarm not set");
    AST_FIN_OFF: assert property (
        up && fs_ff == CAL_SET_DISABLED && !flag_word[CAL_FLG_FINAL_CAPACITY_ALARM] |=> !flag_word[CAL_FLG_FINAL_CAPACITY_ALARM])
        else $error("disabled final alarm set");
    AST_FIN_CLR: assert property (
        vld && remaining_charge > fc_ff && !(remaining_charge < fs_ff && fs_ff != CAL_SET_DISABLED)
        |=> !flag_word[CAL_FLG_FINAL_CAPACITY_ALARM]) else $error("final alarm not cleared");
    AST_MODEL: assert property (
        up |=> control_status[CAL_CTL_LOAD_MODEL_INDICATOR] == $past(load_mode) && comp_power_mode == $past(load_mode))
        else $error("load model bit wrong");
    AST_SHORT: assert property (
        (up && short_detect) [*6] |-> flag_word[CAL_FLG_ISD]) else $error("short flag late");
    AST_TAB: assert property (
        (up && tab_detect) [*6] |-> flag_word[CAL_FLG_TDD]) else $error("tab flag late");
    cover property (flag_word[CAL_FLG_INITIAL_CAPACITY_ALARM] && flag_word[CAL_FLG_FINAL_CAPACITY_ALARM]);
    cover property (vld && remaining_charge > ic_ff && flag_word[CAL_FLG_INITIAL_CAPACITY_ALARM]);
    cover property (up && fs_ff == CAL_SET_DISABLED);
endmodule
bind cal_core cal_core_chk #(.INITIAL_CAPACITY_ALARM_SET(INITIAL_CAPACITY_ALARM_SET), .INITIAL_CAPACITY_ALARM_CLR(INITIAL_CAPACITY_ALARM_CLR), .FINAL_CAPACITY_ALARM_SET(FINAL_CAPACITY_ALARM_SET),
    .FINAL_CAPACITY_ALARM_CLR(FINAL_CAPACITY_ALARM_CLR)) u_cal_core_chk (.clk, .rst_n, .initial_capacity_alarm_set_thr, .initial_capacity_alarm_clr_thr,
    .final_capacity_alarm_set_thr, .final_capacity_alarm_clr_thr, .thr_load, .remaining_charge, .remaining_valid, .short_detect,
    .tab_detect, .load_mode, .flag_word, .control_status, .comp_power_mode);
`default_nettype wire

// ===== test/cal_host.sv
`default_nettype none
// ==========================================
// host side: latches the flag and control words on a read
module cal_host (
    input  wire logic        clk,
    input  wire logic        rd_req,
    input  wire logic [15:0] flag_word,
    input  wire logic [15:0] control_status,
    output var  logic [15:0] host_flags,
    output var  logic [15:0] host_ctl
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk) begin
        if (rd_req) begin
            host_flags <= flag_word;
            host_ctl <= control_status;
        end
    end
endmodule
`default_nettype wire

// ===== test/tb_cal_core.sv
`default_nettype none
module tb_cal_core;
    import cal_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, thr_load, remaining_valid, short_detect, tab_detect;
    logic        load_mode, filt_tick, fcc_valid, rd_req, comp_power_mode;
    logic [2:0]  load_select;
    logic [15:0] s1, c1, sf, cf, remaining_charge, fcc_in, flag_word, control_status;
    logic [15:0] comp_rate, full_charge_capacity_a, host_flags, host_ctl, v;
    logic [15:0] d [11];
    logic [15:0] t1s, t1c, tfs, tfc;
    logic [15:0] walk [11] = '{16'h0096, 16'h0095, 16'h00AF, 16'h00A0, 16'h00B0, 16'h004B,
                               16'h004A, 16'h0064, 16'h005A, 16'h0065, 16'h00C8};
    logic [1:0]  mf;
    int          err_total, n_tests, cyc, seed_dummy;
    cal_core u_cal_core (.clk, .rst_n, .initial_capacity_alarm_set_thr(s1), .initial_capacity_alarm_clr_thr(c1), .final_capacity_alarm_set_thr(sf),
        .final_capacity_alarm_clr_thr(cf), .thr_load, .remaining_charge, .remaining_valid, .short_detect,
        .tab_detect, .load_mode, .load_select, .avg_i_last_run(d[0]), .avg_i_present(d[1]),
        .average_current_reading(d[2]), .voltage_mv(d[3]), .avg_p_last_run(d[4]),
        .avg_p_present(d[5]), .design_capacity(d[6]), .design_energy(d[7]),
        .host_requested_rate(d[8]), .user_current_rate(d[9]), .user_power_rate(d[10]),
        .filt_tick, .fcc_in, .fcc_valid, .flag_word, .control_status, .comp_rate,
        .comp_power_mode, .full_charge_capacity_a);
    cal_host u_cal_host (.clk, .rd_req, .flag_word, .control_status, .host_flags, .host_ctl);
    // ==========================================
    // checking helpers
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // set priority over clear, as the alarms do
    function automatic logic [1:0] nxt(input logic [1:0] f, input logic [15:0] x);
        nxt[1] = (x < t1s) ? 1'b1 : (x > t1c) ? 1'b0 : f[1];
        nxt[0] = (x < tfs && tfs != 16'hFFFF) ? 1'b1 : (x > tfc) ? 1'b0 : f[0];
    endfunction
    function automatic logic [15:0] erate(input logic m, input logic [2:0] s);
        logic signed [31:0] p;
        p = $signed({{16{d[2][15]}}, d[2]}) * $signed({17'h00000, d[3][14:0]});
        case (s)
            3'h0: erate = m ? d[4] : d[0];
            3'h2: erate = m ? p[25:10] : d[2];
            3'h4: erate = (m ? d[7] : d[6]) / 16'h0005;
            3'h5: erate = d[8];
            3'h6: erate = m ? d[10] : d[9];
            default: erate = m ? d[5] : d[1];
        endcase
    endfunction
    task automatic samp(input logic [15:0] x);
        @(posedge clk);
        remaining_charge <= x;
        remaining_valid <= 1'b1;
        mf = nxt(mf, x);
        @(posedge clk);
        remaining_valid <= 1'b0;
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        #1;
        chk("init_alarm", 16'(mf[1]), 16'(host_flags[CAL_FLG_INITIAL_CAPACITY_ALARM]));
        chk("final_alarm", 16'(mf[0]), 16'(host_flags[CAL_FLG_FINAL_CAPACITY_ALARM]));
    endtask
    task automatic setthr(input logic [15:0] a, b, e, g);
        @(posedge clk);
        {s1, c1, sf, cf} <= {a, b, e, g};
        {t1s, t1c, tfs, tfc} = {a, b, e, g};
        thr_load <= 1'b1;
        @(posedge clk);
        thr_load <= 1'b0;
    endtask
    // ==========================================
    // clock, tick stimulus, watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        filt_tick <= ($urandom & 3) == 0;
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            end_of_test();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        {rst_n, thr_load, remaining_valid, short_detect, tab_detect} = '0;
        {load_mode, fcc_valid, rd_req, load_select, mf} = '0;
        {s1, c1, sf, cf, remaining_charge, fcc_in} = '0;
        {t1s, t1c, tfs, tfc} = {16'h0096, 16'h00AF, 16'h004B, 16'h0064};
        foreach (d[k]) d[k] = '0;
        seed_dummy = $urandom(33);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("flags_rst", 16'h0000, flag_word);
        foreach (walk[k]) samp(walk[k]);
        for (int i = 0; i < 40; i++) begin
            if (i % 10 == 0) begin
                v = 16'($urandom & 32'h03FF);
                setthr(v, v + 16'($urandom & 32'h3F), (i == 20) ? 16'hFFFF : v >> 1, v);
            end
            samp(16'($urandom & 32'h03FF));
        end
        samp(16'h7FFF);
        setthr(16'h0096, 16'h00AF, 16'hFFFF, 16'h0064);
        samp(16'h0000);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            foreach (d[k]) d[k] <= 16'($urandom & 32'h7FFF);
            load_mode <= i[3];
            load_select <= i[2:0];
            repeat (2) @(posedge clk);
            #1;
            chk("model", 16'(i[3]), 16'(control_status[CAL_CTL_LOAD_MODEL_INDICATOR]));
            chk("power_mode", 16'(i[3]), 16'(comp_power_mode));
            if (i[2:0] != 3) chk("rate", erate(i[3], i[2:0]), comp_rate);
        end
        @(posedge clk);
        {short_detect, tab_detect} <= 2'b11;
        repeat (8) @(posedge clk);
        #1;
        chk("short", 16'h0001, 16'(flag_word[CAL_FLG_ISD]));
        chk("tab", 16'h0001, 16'(flag_word[CAL_FLG_TDD]));
        v = 16'($urandom & 32'h7FFF);
        @(posedge clk);
        fcc_in <= v;
        fcc_valid <= 1'b1;
        @(posedge clk);
        fcc_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("fcc", v, full_charge_capacity_a);
        end_of_test();
    end
endmodule
`default_nettype wire
